/* hdl/khm_cfg.svh */
// constants for the keyboard host mailbox port
`ifndef KHM_CFG_SVH
`define KHM_CFG_SVH
`define KHM_ADDR_DATA 8'h60
`define KHM_ADDR_CMD 8'h64
`define KHM_ST_OBF 0
`define KHM_ST_IBF 1
`define KHM_ST_CD 3
`define KHM_ST_RESET 8'h00
`define KHM_ST_UD_MASK 8'hf4
`define KHM_CLK_NS 5
`define KHM_QUASI_HOLD_NS 500
`define KHM_QUASI_HOLD_CYC ((`KHM_QUASI_HOLD_NS + `KHM_CLK_NS - 1) / `KHM_CLK_NS)
`endif

/* hdl/khm_pkg.sv */
// types for the keyboard host mailbox port
package khm_pkg;
    typedef enum logic [2:0] {
        KHM_RUN = 3'b001,
        KHM_HALT = 3'b010,
        KHM_STOP = 3'b100
    } khm_pwr_e;
endpackage : khm_pkg

/* hdl/khm_quasi_pin.sv */
// one quasi-bidirectional or open-drain port pin driver
`timescale 1ns/100ps
`include "khm_cfg.svh"
module khm_quasi_pin
    import khm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // control
    input wire logic port_bit,
    input wire logic open_drain,
    // pin
    output logic pin_o,
    output logic pin_oe_n
);
    typedef struct packed {
        logic last;
        logic [7:0] cnt;
    } khm_qp_s;
    khm_qp_s st_q, st_d;

    // count the strong-high window after a rising port bit
    always_comb begin
        st_d = st_q;
        st_d.last = port_bit;
        if (port_bit && !st_q.last) begin
            st_d.cnt = 8'(`KHM_QUASI_HOLD_CYC);
        end else if (st_q.cnt != 8'h00) begin
            st_d.cnt = st_q.cnt - 8'h01;
        end
        if (!port_bit) begin
            st_d.cnt = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // zero drives low; in quasi mode one drives from its first cycle, then floats; in open drain one floats
    assign pin_o = port_bit & !open_drain; // R16 R17
    assign pin_oe_n = !(!port_bit || (!open_drain && (!st_q.last || st_q.cnt != 8'h00))); // R16 R17

    quasi_release_a: assert property (@(posedge core_clk) disable iff (rst) // R16
        (clk_en && port_bit && !st_q.last && !open_drain) |=> !pin_oe_n [*8])
        else $error("quasi pin released too early");
    od_float_a: assert property (@(posedge core_clk) disable iff (rst) // R17
        (open_drain && port_bit) |-> pin_oe_n)
        else $error("open drain pin driven high");
endmodule : khm_quasi_pin

/* hdl/khm_host_port.sv */
// keyboard controller host mailbox: host registers, core side, irqs and pins
//
// What this block does
// R1 - data write loads buffer, clears cd, sets full
// R2 - command write loads buffer, sets cd, full
// R3 - data read; flag mode clears obf, irq
// R4 - without flag mode firmware clears irq
// R5 - core output write loads buffer, sets obf
// R6 - core input read clears ibf and interrupt
// R7 - status layout: cd, ibf, obf, user bits
// R8 - status host read-only, core writable, reset zero
// R9 - host write copies address bit two into cd
// R10 - flag mode keyboard irq follows obf gated
// R11 - direct mode keyboard irq follows port bit
// R12 - keyboard irq low after reset
// R13 - flag mode mouse irq is inverted ibf gated
// R14 - direct mode mouse irq follows port bit
// R15 - port bit drives a20 gate output
// R16 - quasi pins: brief strong high then release
// R17 - open drain: one floats, zero drives low
// R18 - keyboard/mouse pins inverted, read back
// R19 - halt stops alu; reset or write wakes
// R20 - stop kills oscillator; same exits
// R21 - two core interrupts: ibf, timer overflow
// R22 - reset lasts at least 24 clocks
// R23 - flag mode sticky until reset
`timescale 1ns/100ps
`include "khm_cfg.svh"
module khm_host_port
    import khm_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // host i/o cycle side
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // controller core side
    input wire logic core_out_wr,
    input wire logic [7:0] core_out_data,
    input wire logic core_in_rd,
    output logic [7:0] core_in_data,
    input wire logic core_st_wr,
    input wire logic [7:0] core_st_data,
    output logic [7:0] core_status,
    input wire logic core_en_flags,
    input wire logic [7:0] core_port2_wr,
    input wire logic core_port2_we,
    input wire logic [2:0] core_quasi_bits,
    input wire logic core_open_drain,
    input wire logic core_halt,
    input wire logic core_stop,
    input wire logic core_ibf_int_en,
    input wire logic timer_ovf,
    // core power and interrupt outputs
    output logic core_alu_run,
    output logic core_osc_run,
    output logic core_wake_pulse,
    output logic core_ibf_irq,
    output logic core_timer_irq,
    // host interrupts and a20
    output logic keyboard_irq_out,
    output logic mouse_irq_out,
    output logic a20_gate_out,
    // kbd/mouse open-drain pins
    input wire logic kb_clock_pin_i,
    input wire logic kb_data_pin_i,
    input wire logic ms_clock_pin_i,
    input wire logic ms_data_pin_i,
    output logic kb_clock_pin_oe_n,
    output logic kb_data_pin_oe_n,
    output logic ms_clock_pin_oe_n,
    output logic ms_data_pin_oe_n,
    output logic kps_pin_o,
    // sense back to core
    output logic kb_clock_sense_in,
    output logic kb_data_sense_in,
    output logic ms_clock_sense_in,
    output logic ms_data_sense_in,
    // quasi pins a, b, c
    output logic [2:0] quasi_pin_o,
    output logic [2:0] quasi_pin_oe_n
);
    // ========================================
    // state
    typedef struct packed {
        logic [7:0] input_buffer_reg;
        logic [7:0] out_buf;
        logic [7:0] status;
        logic flags_en;
        logic [7:0] port2;
        khm_pwr_e pwr;
        logic wake;
        logic [7:0] rdata;
    } khm_st_s;
    khm_st_s st_q, st_d;

    // host address decode
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction : is_addr

    logic host_dw, host_cw, host_dr, host_any_w;
    assign host_dw = host_wr && is_addr(host_addr, `KHM_ADDR_DATA);
    assign host_cw = host_wr && is_addr(host_addr, `KHM_ADDR_CMD);
    assign host_dr = host_rd && is_addr(host_addr, `KHM_ADDR_DATA);
    assign host_any_w = host_dw || host_cw;

    // ========================================
    // next-state logic
    always_comb begin
        st_d = st_q;
        st_d.wake = 1'b0;
        // core writes user bits of status
        if (core_st_wr) begin
            st_d.status = (st_q.status & ~`KHM_ST_UD_MASK) | (core_st_data & `KHM_ST_UD_MASK); // R7 R8
        end
        // core reads input buffer
        if (core_in_rd) begin
            st_d.status[`KHM_ST_IBF] = 1'b0; // R6
        end
        // host read of data clears obf in flag mode
        if (host_dr && st_q.flags_en) begin
            st_d.status[`KHM_ST_OBF] = 1'b0; // R3
        end
        // core output write wins over clearing read
        if (core_out_wr) begin
            st_d.out_buf = core_out_data; // R5
            st_d.status[`KHM_ST_OBF] = 1'b1; // R5
        end
        // host write; set wins over core clear
        if (host_any_w) begin
            st_d.input_buffer_reg = host_wdata; // R1 R2
            st_d.status[`KHM_ST_CD] = host_addr[2]; // R1 R2 R9
            st_d.status[`KHM_ST_IBF] = 1'b1; // R1 R2
        end
        if (core_en_flags) begin
            st_d.flags_en = 1'b1; // R23
        end
        if (core_port2_we) begin
            st_d.port2 = core_port2_wr;
        end
        // host read mux
        if (is_addr(host_addr, `KHM_ADDR_DATA)) begin
            st_d.rdata = st_q.out_buf; // R3
        end else if (is_addr(host_addr, `KHM_ADDR_CMD)) begin
            st_d.rdata = st_q.status; // R8
        end else begin
            st_d.rdata = 8'h00;
        end
        // power modes
        case (st_q.pwr)
            KHM_RUN: begin
                if (core_stop) begin
                    st_d.pwr = KHM_STOP; // R20
                end else if (core_halt) begin
                    st_d.pwr = KHM_HALT; // R19
                end
            end
            KHM_HALT, KHM_STOP: begin
                if (host_any_w) begin
                    st_d.pwr = KHM_RUN; // R19 R20
                    st_d.wake = 1'b1;
                end
            end
            default: begin
                st_d.pwr = KHM_RUN;
            end
        endcase
    end

    // registers; reset clears state, zeroes status and returns the power mode to run
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.status <= `KHM_ST_RESET; // R8
            st_q.pwr <= KHM_RUN; // R19 R20
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // ========================================
    // outputs
    assign host_rdata = st_q.rdata;
    assign core_in_data = st_q.input_buffer_reg; // R6
    assign core_status = st_q.status;
    assign core_alu_run = st_q.pwr == KHM_RUN; // R19
    assign core_osc_run = st_q.pwr != KHM_STOP; // R20
    assign core_wake_pulse = st_q.wake;
    assign core_ibf_irq = st_q.status[`KHM_ST_IBF] && core_ibf_int_en; // R21 R6
    assign core_timer_irq = timer_ovf; // R21

    // port 2 bit positions
    localparam int A20_B = 1;
    localparam int MSD_B = 2;
    localparam int MSC_B = 3;
    localparam int KBI_B = 4;
    localparam int MSI_B = 5;
    localparam int KBC_B = 6;
    localparam int KBD_B = 7;

    // host interrupts: flag mode gates, else direct
    assign keyboard_irq_out = st_q.flags_en ?
        (st_q.port2[KBI_B] && st_q.status[`KHM_ST_OBF]) : st_q.port2[KBI_B]; // R10 R11 R12 R4
    assign mouse_irq_out = st_q.flags_en ?
        (st_q.port2[MSI_B] && !st_q.status[`KHM_ST_IBF]) : st_q.port2[MSI_B]; // R13 R14
    assign a20_gate_out = st_q.port2[A20_B]; // R15

    // open-drain pins: bit one inverts to drive low
    assign kps_pin_o = 1'b0;
    assign kb_clock_pin_oe_n = !st_q.port2[KBC_B]; // R18
    assign kb_data_pin_oe_n = !st_q.port2[KBD_B]; // R18
    assign ms_clock_pin_oe_n = !st_q.port2[MSC_B]; // R18
    assign ms_data_pin_oe_n = !st_q.port2[MSD_B]; // R18
    assign kb_clock_sense_in = kb_clock_pin_i; // R18
    assign kb_data_sense_in = kb_data_pin_i; // R18
    assign ms_clock_sense_in = ms_clock_pin_i; // R18
    assign ms_data_sense_in = ms_data_pin_i; // R18

    // quasi-bidirectional pins
    for (genvar i = 0; i < 3; i++) begin : g_quasi
        khm_quasi_pin u_pin (
            .core_clk(core_clk),
            .rst(rst),
            .clk_en(clk_en),
            .port_bit(core_quasi_bits[i]),
            .open_drain(core_open_drain),
            .pin_o(quasi_pin_o[i]),
            .pin_oe_n(quasi_pin_oe_n[i])
        );
    end

    // ========================================
    // checks
    sequence host_data_wr_s;
        clk_en && host_dw;
    endsequence
    sequence host_cmd_wr_s;
        clk_en && host_cw;
    endsequence

    // host writes and core strobes
    data_write_a: assert property (@(posedge core_clk) disable iff (rst) // R1
        host_data_wr_s |=> (st_q.status[`KHM_ST_CD] == 1'b0 && st_q.status[`KHM_ST_IBF]
        && core_in_data == $past(host_wdata)))
        else $error("data write did not load buffer");
    cmd_write_a: assert property (@(posedge core_clk) disable iff (rst) // R2
        host_cmd_wr_s |=> (st_q.status[`KHM_ST_CD] && st_q.status[`KHM_ST_IBF]))
        else $error("command write did not set cd");
    read_clear_a: assert property (@(posedge core_clk) disable iff (rst) // R3
        (clk_en && host_dr && st_q.flags_en && !core_out_wr) |=> !keyboard_irq_out)
        else $error("flag mode read left irq high");
    out_write_a: assert property (@(posedge core_clk) disable iff (rst) // R5
        (clk_en && core_out_wr) |=> (core_status[`KHM_ST_OBF] && st_q.out_buf == $past(core_out_data)))
        else $error("core write did not set obf");
    in_read_a: assert property (@(posedge core_clk) disable iff (rst) // R6
        (clk_en && core_in_rd && !host_any_w) |=> !core_ibf_irq)
        else $error("core read left ibf set");
    kb_irq_a: assert property (@(posedge core_clk) disable iff (rst) // R10
        st_q.flags_en && !st_q.port2[KBI_B] |-> !keyboard_irq_out)
        else $error("keyboard irq not forced low");
    ms_irq_a: assert property (@(posedge core_clk) disable iff (rst) // R13
        st_q.flags_en && st_q.port2[MSI_B] |-> mouse_irq_out == !core_status[`KHM_ST_IBF])
        else $error("mouse irq not inverted ibf");
    flag_sticky_a: assert property (@(posedge core_clk) disable iff (rst) // R23
        st_q.flags_en |=> st_q.flags_en)
        else $error("flag mode dropped");
    reset_irq_a: assert property (@(posedge core_clk) // R12 R8
        $fell(rst) |-> !keyboard_irq_out && core_status == 8'h00)
        else $error("irq or status not clear after reset");
    halt_wake_a: assert property (@(posedge core_clk) disable iff (rst) // R19
        (clk_en && st_q.pwr == KHM_HALT && host_any_w) |=> core_alu_run && core_wake_pulse)
        else $error("halt not exited on host write");
    stop_osc_a: assert property (@(posedge core_clk) disable iff (rst) // R20
        (clk_en && st_q.pwr == KHM_RUN && core_stop) |=> !core_osc_run)
        else $error("stop left oscillator running");

    // flag-mode interrupt steps
    sequence flag_out_wr_s;
        clk_en && core_out_wr && st_q.flags_en && st_q.port2[KBI_B] && !core_port2_we;
    endsequence
    sequence flag_in_rd_s;
        clk_en && core_in_rd && !host_any_w && st_q.flags_en && st_q.port2[MSI_B] && !core_port2_we;
    endsequence

    kb_rise_a: assert property (@(posedge core_clk) disable iff (rst) // R10
        flag_out_wr_s |=> keyboard_irq_out)
        else $error("keyboard irq not raised by core write");
    ms_done_a: assert property (@(posedge core_clk) disable iff (rst) // R13
        flag_in_rd_s |=> mouse_irq_out)
        else $error("mouse irq not raised by core read");
    wake_once_a: assert property (@(posedge core_clk) disable iff (rst) // R19
        (clk_en && core_wake_pulse) |=> !core_wake_pulse)
        else $error("wake pulse longer than one cycle");

    // host read answers one cycle later
    rd_status_a: assert property (@(posedge core_clk) disable iff (rst) // R8
        (clk_en && host_rd && host_addr == `KHM_ADDR_CMD) |=> host_rdata == $past(core_status))
        else $error("status read returned wrong byte");
    rd_data_a: assert property (@(posedge core_clk) disable iff (rst) // R3
        (clk_en && host_dr) |=> host_rdata == $past(st_q.out_buf))
        else $error("data read returned wrong byte");
endmodule : khm_host_port

/* sim/khm_host_model.sv */
// host-side model issuing i/o reads and writes to the mailbox port
`timescale 1ns/100ps
module khm_host_model (
    // clock
    input wire logic core_clk,
    // i/o cycle
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    // idle bus at time zero
    initial begin
        {host_wr, host_rd} = 2'b00;
        {host_addr, host_wdata} = 16'h0000;
    end
    // one-cycle write after an idle edge; lines scrambled on release so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        {host_addr, host_wdata, host_wr} = {a, d, 1'b1};
        @(posedge core_clk);
        #1;
        {host_addr, host_wdata, host_wr} = {~a, ~d, 1'b0};
    endtask : wr
    // one-cycle read after an idle edge; answer is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        {host_addr, host_rd} = {a, 1'b1};
        @(posedge core_clk);
        #1;
        d = host_rdata;
        {host_addr, host_rd} = {~a, 1'b0};
    endtask : rd
endmodule : khm_host_model

/* sim/khm_host_port_bench.sv */
// self-checking bench for the keyboard host mailbox port
`timescale 1ns/100ps
module khm_host_port_bench;
    // ==========
    // signals
    logic core_clk, rst, clk_en, host_wr, host_rd, core_out_wr, core_in_rd, core_st_wr, core_en_flags;
    logic core_port2_we, core_open_drain, core_halt, core_stop, core_ibf_int_en, timer_ovf, kps_pin_o;
    logic core_alu_run, core_osc_run, core_wake_pulse, core_ibf_irq, core_timer_irq;
    logic keyboard_irq_out, mouse_irq_out, a20_gate_out;
    logic kb_clock_pin_i, kb_data_pin_i, ms_clock_pin_i, ms_data_pin_i;
    logic kb_clock_pin_oe_n, kb_data_pin_oe_n, ms_clock_pin_oe_n, ms_data_pin_oe_n;
    logic kb_clock_sense_in, kb_data_sense_in, ms_clock_sense_in, ms_data_sense_in;
    logic [7:0] host_addr, host_wdata, host_rdata, core_out_data, core_in_data, core_st_data;
    logic [7:0] core_status, core_port2_wr, rdv, irqv, pinv, sensev;
    logic [2:0] core_quasi_bits, quasi_pin_o, quasi_pin_oe_n;
    int num_errors, tests_run, cycles;
    // pull-ups on the open-drain lines
    assign kb_clock_pin_i = kb_clock_pin_oe_n | kps_pin_o;
    assign kb_data_pin_i = kb_data_pin_oe_n | kps_pin_o;
    assign ms_clock_pin_i = ms_clock_pin_oe_n | kps_pin_o;
    assign ms_data_pin_i = ms_data_pin_oe_n | kps_pin_o;
    // grouped views for compares
    assign irqv = {5'd0, keyboard_irq_out, mouse_irq_out, a20_gate_out};
    assign pinv = {4'd0, kb_clock_pin_oe_n, kb_data_pin_oe_n, ms_clock_pin_oe_n, ms_data_pin_oe_n};
    assign sensev = {4'd0, kb_clock_sense_in, kb_data_sense_in, ms_clock_sense_in, ms_data_sense_in};
    khm_host_port i_khm_host_port (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .host_wr(host_wr),
        .host_rd(host_rd),
        .host_addr(host_addr),
        .host_wdata(host_wdata),
        .host_rdata(host_rdata),
        .core_out_wr(core_out_wr),
        .core_out_data(core_out_data),
        .core_in_rd(core_in_rd),
        .core_in_data(core_in_data),
        .core_st_wr(core_st_wr),
        .core_st_data(core_st_data),
        .core_status(core_status),
        .core_en_flags(core_en_flags),
        .core_port2_wr(core_port2_wr),
        .core_port2_we(core_port2_we),
        .core_quasi_bits(core_quasi_bits),
        .core_open_drain(core_open_drain),
        .core_halt(core_halt),
        .core_stop(core_stop),
        .core_ibf_int_en(core_ibf_int_en),
        .timer_ovf(timer_ovf),
        .core_alu_run(core_alu_run),
        .core_osc_run(core_osc_run),
        .core_wake_pulse(core_wake_pulse),
        .core_ibf_irq(core_ibf_irq),
        .core_timer_irq(core_timer_irq),
        .keyboard_irq_out(keyboard_irq_out),
        .mouse_irq_out(mouse_irq_out),
        .a20_gate_out(a20_gate_out),
        .kb_clock_pin_i(kb_clock_pin_i),
        .kb_data_pin_i(kb_data_pin_i),
        .ms_clock_pin_i(ms_clock_pin_i),
        .ms_data_pin_i(ms_data_pin_i),
        .kb_clock_pin_oe_n(kb_clock_pin_oe_n),
        .kb_data_pin_oe_n(kb_data_pin_oe_n),
        .ms_clock_pin_oe_n(ms_clock_pin_oe_n),
        .ms_data_pin_oe_n(ms_data_pin_oe_n),
        .kps_pin_o(kps_pin_o),
        .kb_clock_sense_in(kb_clock_sense_in),
        .kb_data_sense_in(kb_data_sense_in),
        .ms_clock_sense_in(ms_clock_sense_in),
        .ms_data_sense_in(ms_data_sense_in),
        .quasi_pin_o(quasi_pin_o),
        .quasi_pin_oe_n(quasi_pin_oe_n)
    );
    khm_host_model i_khm_host_model (
        .core_clk(core_clk),
        .host_wr(host_wr),
        .host_rd(host_rd),
        .host_addr(host_addr),
        .host_wdata(host_wdata),
        .host_rdata(host_rdata)
    );
    // 200 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
    end
    // ==========
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one idle edge first so a strobe never drops and rises in one time step
    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic port2(input logic [7:0] v);
        core_port2_wr = v;
        pulse(core_port2_we);
    endtask : port2
    task automatic hr(input logic [7:0] a, input logic [7:0] e);
        i_khm_host_model.rd(a, rdv);
        chk("host rdata", e, rdv);
    endtask : hr
    task automatic reset_dut();
        rst = 1'b1;
        cyc(24);
        rst = 1'b0;
    endtask : reset_dut
    task automatic close_out();
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        {rst, clk_en, core_ibf_int_en, core_open_drain, core_halt, core_stop, timer_ovf} = 7'b1110000;
        {core_out_wr, core_in_rd, core_st_wr, core_en_flags, core_port2_we} = 5'b00000;
        {core_out_data, core_st_data, core_port2_wr, core_quasi_bits} = 27'h0;
        reset_dut();
        chk("status", 8'h00, core_status);
        chk("irqs", 8'h00, irqv);
        chk("pins", 8'h0f, pinv);
        chk("power", 8'h03, {6'd0, core_alu_run, core_osc_run});
        hr(8'h64, 8'h00);
        // host bytes and status layout
        i_khm_host_model.wr(8'h60, 8'ha5);
        chk("status", 8'h02, core_status);
        chk("in data", 8'ha5, core_in_data);
        chk("ibf irq", 8'h01, core_ibf_irq);
        i_khm_host_model.wr(8'h64, 8'h3c);
        hr(8'h64, 8'h0a);
        chk("in data", 8'h3c, core_in_data);
        i_khm_host_model.wr(8'h61, 8'h00);
        chk("in data", 8'h3c, core_in_data);
        core_st_data = 8'hff;
        pulse(core_st_wr);
        chk("status", 8'hfe, core_status);
        pulse(core_in_rd);
        chk("status", 8'hfc, core_status);
        chk("ibf irq", 8'h00, core_ibf_irq);
        core_st_data = 8'h00;
        pulse(core_st_wr);
        chk("status", 8'h08, core_status);
        // direct irq mode and keyboard lines
        port2(8'hfe);
        chk("irqs", 8'h07, irqv);
        chk("pins", 8'h00, pinv);
        chk("sense", 8'h00, sensev);
        port2(8'h50);
        chk("irqs", 8'h04, irqv);
        chk("pins", 8'h07, pinv);
        chk("sense", 8'h07, sensev);
        core_out_data = 8'h5a;
        pulse(core_out_wr);
        chk("status", 8'h09, core_status);
        hr(8'h60, 8'h5a);
        chk("irqs", 8'h04, irqv);
        chk("status", 8'h09, core_status);
        port2(8'h00);
        chk("irqs", 8'h00, irqv);
        // flag mode
        pulse(core_en_flags);
        port2(8'h30);
        core_out_data = 8'hc3;
        pulse(core_out_wr);
        chk("irqs", 8'h06, irqv);
        hr(8'h60, 8'hc3);
        chk("irqs", 8'h02, irqv);
        chk("status", 8'h08, core_status);
        i_khm_host_model.wr(8'h60, 8'h77);
        chk("status", 8'h02, core_status);
        chk("irqs", 8'h00, irqv);
        pulse(core_in_rd);
        chk("irqs", 8'h02, irqv);
        core_out_data = 8'h11;
        pulse(core_out_wr);
        port2(8'h20);
        chk("irqs", 8'h02, irqv);
        // powerdown and exits
        pulse(core_halt);
        chk("power", 8'h01, {6'd0, core_alu_run, core_osc_run});
        i_khm_host_model.wr(8'h64, 8'h00);
        chk("wake", 8'h01, core_wake_pulse);
        cyc(1);
        chk("power", 8'h03, {6'd0, core_alu_run, core_osc_run});
        chk("wake", 8'h00, core_wake_pulse);
        pulse(core_stop);
        chk("osc", 8'h00, core_osc_run);
        i_khm_host_model.wr(8'h60, 8'h00);
        cyc(1);
        chk("osc", 8'h01, core_osc_run);
        timer_ovf = 1'b1;
        cyc(1);
        chk("timer irq", 8'h01, core_timer_irq);
        timer_ovf = 1'b0;
        // clock enable low freezes the core read
        clk_en = 1'b0;
        pulse(core_in_rd);
        chk("frozen status", 8'h03, core_status);
        clk_en = 1'b1;
        pulse(core_in_rd);
        chk("status", 8'h01, core_status);
        // quasi pins: strong high then release, open drain
        core_quasi_bits = 3'b111;
        cyc(2);
        chk("quasi", 8'h07, {2'd0, quasi_pin_oe_n, quasi_pin_o});
        cyc(90);
        chk("quasi oe", 8'h00, {5'd0, quasi_pin_oe_n});
        cyc(20);
        chk("quasi oe", 8'h07, {5'd0, quasi_pin_oe_n});
        core_quasi_bits = 3'b000;
        cyc(2);
        chk("quasi", 8'h00, {2'd0, quasi_pin_oe_n, quasi_pin_o});
        {core_open_drain, core_quasi_bits} = 4'b1101;
        cyc(2);
        chk("quasi oe", 8'h05, {5'd0, quasi_pin_oe_n});
        // second reset drops flag mode
        reset_dut();
        chk("status", 8'h00, core_status);
        chk("irqs", 8'h00, irqv);
        port2(8'h10);
        chk("irqs", 8'h04, irqv);
        close_out();
    end
endmodule : khm_host_port_bench
